/* File: bench/cca_capture_compare_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cca_capture_compare_monitor
    import cca_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] modulePinOut,
    input wire logic [2:0] modulePinOe,
    input wire logic watchdogReset
);
    logic wdOn;
    logic lockOn;
    logic wrAcc;
    assign wrAcc = psel && penable && pwrite;
    // Shadow of the watchdog enable and lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdOn <= 1'b1;
            lockOn <= 1'b0;
        end else if (wrAcc && paddr == OFS_MODE && !lockOn) begin
            wdOn <= pwdata[MD_WATCHDOG_ENABLE] | pwdata[MD_LOCK];
            lockOn <= pwdata[MD_LOCK];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_slverr_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_unmapped_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_reset_one_pulse: assert property ($rose(watchdogReset) |=> !watchdogReset)
        else $error("watchdog reset longer than one cycle");
    a_flag_forces_reset: assert property (wrAcc && wdOn && paddr == OFS_CTRL && pwdata[2]
        |-> ##[1:2] watchdogReset) else $error("forced watchdog reset missing");
    a_wd_mode_reads: assert property (psel && penable && !pwrite && paddr == OFS_MODE
        && wdOn |-> prdata[MD_WATCHDOG_ENABLE]) else $error("watchdog enable reads zero");
    a_wd_pin_free: assert property (wdOn |-> !modulePinOe[2])
        else $error("module 2 drives pin under watchdog");
    a_no_reset_off: assert property (!wdOn && !$past(wdOn) |-> !watchdogReset)
        else $error("watchdog reset while disabled");
    c_wd_reset: cover property (watchdogReset);
    c_unmapped: cover property (pslverr);
    c_pwm_rise: cover property ($rose(modulePinOut[0]));
endmodule : cca_capture_compare_monitor
bind cca_capture_compare cca_capture_compare_monitor mon_u (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .modulePinOut(modulePinOut),
    .modulePinOe(modulePinOe), .watchdogReset(watchdogReset));
`default_nettype wire

/* File: bench/cca_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
    input wire logic clk,
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    input wire logic [2:0] extLevel,
    output logic [2:0] pinIn
);
    logic [2:0] last;
    logic [2:0] held;
    // Levels shorter than two clocks never reach the pin
    always_ff @(posedge clk) begin
        last <= extLevel;
        if (last == extLevel) begin
            held <= extLevel;
        end
    end
    // Driven pins read back their own drive
    assign pinIn = (pinOe & pinOut) | (~pinOe & held);
endmodule : cca_pin_model
`default_nettype wire

/* File: bench/test_cca_capture_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cca_capture_compare
    import cca_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cpuIdle, irqReq, watchdogReset;
    logic [7:0] paddr, rd, md;
    logic [31:0] pwdata, prdata;
    logic [2:0] pinIn, pinOut, pinOe, extLevel;
    logic [15:0] expQ[$];
    logic [15:0] e;
    int miscompares, comparisons, seed, n, i, k, t;
    cca_capture_compare dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modulePinIn(pinIn), .modulePinOut(pinOut), .modulePinOe(pinOe),
        .cpuIdle(cpuIdle), .irqReq(irqReq), .watchdogReset(watchdogReset));
    cca_pin_model pin_u (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
        .pinIn(pinIn));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
        input logic [15:0] ex);
        int w;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        if (!wr) begin
            expQ.push_back(ex);
        end
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (w >= 20) begin
            miscompares++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // High cycles and toggles of one pin over a window
    task automatic sample(input int b, input int len, output int hi, output int tg);
        logic p;
        hi = 0;
        tg = 0;
        p = pinOut[b];
        repeat (len) begin
            @(posedge clk);
            hi += pinOut[b];
            tg += (pinOut[b] != p);
            p = pinOut[b];
        end
    endtask : sample
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            e = expQ.pop_front();
            check({8'h0, prdata[7:0] & e[15:8]}, {8'h0, e[7:0]});
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        seed = 35839;
        {rst_n, psel, penable, pwrite, cpuIdle} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        extLevel = 3'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_MODE, 8'h00, {8'hFF, RST_MODE});
        apb(1'b0, OFS_CTRL, 8'h00, 16'hFF00);
        apb(1'b0, 8'hFC, 8'h00, 16'hFF00);
        // Timebase frozen while the watchdog is on
        apb(1'b1, OFS_MODE, 8'h08, 16'h0);
        apb(1'b0, OFS_MODE, 8'h00, 16'hFF00);
        apb(1'b1, OFS_MODE, 8'h08, 16'h0);
        apb(1'b0, OFS_MODE, 8'h00, 16'hFF08);
        for (i = 0; i < 3; i++) begin
            md = {2'b00, i != 1, i != 0, 4'h1};
            apb(1'b1, OFS_MODREG + OFS_STRIDE, md, 16'h0);
            for (k = 0; k < 2; k++) begin
                rd = 8'($random(seed));
                apb(1'b1, OFS_CNT_LO, rd, 16'h0);
                apb(1'b1, OFS_CTRL, 8'h00, 16'h0);
                extLevel[1] <= ~extLevel[1];
                repeat (8) @(posedge clk);
                apb(1'b0, OFS_CTRL, 8'h00, {8'hFF, 6'h0, md[5 - k], 1'b0});
                check({15'h0, irqReq}, {15'h0, md[5 - k]});
                check({13'h0, pinOe[1], pinIn[1], 1'b0}, {14'h0, extLevel[1], 1'b0});
                apb(1'b0, OFS_CMP_LO + OFS_STRIDE, 8'h00, {{8{md[5 - k]}}, rd & {8{md[5 - k]}}});
            end
        end
        apb(1'b1, OFS_MODREG + OFS_STRIDE, 8'h00, 16'h0);
        apb(1'b1, OFS_MODREG, 8'h49, 16'h0);
        apb(1'b1, OFS_CMP_LO, 8'h10, 16'h0);
        apb(1'b0, OFS_MODREG, 8'h00, 16'hFF09);
        apb(1'b1, OFS_CMP_HI, 8'h00, 16'h0);
        apb(1'b0, OFS_MODREG, 8'h00, 16'hFF49);
        apb(1'b1, OFS_CNT_LO, 8'h00, 16'h0);
        apb(1'b1, OFS_CTRL, 8'h40, 16'h0);
        repeat (20) @(posedge clk);
        apb(1'b0, OFS_CTRL, 8'h00, 16'hFF41);
        check({15'h0, irqReq}, 16'h1);
        rd = 8'($random(seed));
        apb(1'b1, OFS_MODREG, 8'h42, 16'h0);
        apb(1'b1, OFS_CMP_LO, rd, 16'h0);
        apb(1'b1, OFS_CMP_HI, rd, 16'h0);
        for (k = 0; k < 2; k++) begin
            repeat (256) @(posedge clk);
            n = 0;
            repeat (512) begin
                @(posedge clk);
                n += pinOut[0];
            end
            check(n[15:0], k == 0 ? 16'(512 - 2 * rd) : 16'h0);
            apb(1'b1, OFS_CMP_LO, rd, 16'h0);
        end
        // Frequency output on module 1: half period 64, then zero as 256
        apb(1'b1, OFS_MODREG + OFS_STRIDE, 8'h46, 16'h0);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, OFS_CMP_HI + OFS_STRIDE, k == 0 ? 8'h40 : 8'h00, 16'h0);
            repeat (256) @(posedge clk);
            sample(1, 512, n, t);
            check(t[15:0], k == 0 ? 16'h0008 : 16'h0002);
        end
        // High-speed output: one toggle at 0x1234
        apb(1'b1, OFS_MODREG + OFS_STRIDE, 8'h0C, 16'h0);
        apb(1'b1, OFS_CTRL, 8'h00, 16'h0);
        apb(1'b1, OFS_CMP_LO + OFS_STRIDE, 8'h34, 16'h0);
        apb(1'b1, OFS_CNT_HI, 8'h12, 16'h0);
        apb(1'b1, OFS_CNT_LO, 8'h00, 16'h0);
        apb(1'b1, OFS_CMP_HI + OFS_STRIDE, 8'h12, 16'h0);
        apb(1'b1, OFS_CTRL, 8'h40, 16'h0);
        sample(1, 100, n, t);
        check(t[15:0], 16'h0001);
        apb(1'b0, OFS_CTRL, 8'h00, 16'h0202);
        // 16-bit PWM: high from 0xFF80 until overflow
        apb(1'b1, OFS_CTRL, 8'h00, 16'h0);
        apb(1'b1, OFS_MODREG + OFS_STRIDE, 8'h8B, 16'h0);
        apb(1'b1, OFS_CMP_LO + OFS_STRIDE, 8'h80, 16'h0);
        apb(1'b1, OFS_CMP_HI + OFS_STRIDE, 8'hFF, 16'h0);
        apb(1'b1, OFS_CNT_HI, 8'hFF, 16'h0);
        apb(1'b1, OFS_CNT_LO, 8'h00, 16'h0);
        apb(1'b1, OFS_CTRL, 8'h40, 16'h0);
        n = 0;
        while (irqReq !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            miscompares++;
            end_of_test();
        end
        i = pinOut[1];
        sample(1, 255, n, t);
        check(16'(n + i), 16'h0080);
        check(t[15:0], 16'h0001);
        // Watchdog from a known low byte
        apb(1'b1, OFS_CTRL, 8'h00, 16'h0);
        apb(1'b1, OFS_CNT_LO, 8'h00, 16'h0);
        apb(1'b1, OFS_CMP_LO + 8'h08, 8'h00, 16'h0);
        apb(1'b1, OFS_MODE, 8'h48, 16'h0);
        apb(1'b1, OFS_CMP_HI + 8'h08, 8'h5A, 16'h0);
        apb(1'b1, OFS_MODE, 8'h4E, 16'h0);
        apb(1'b0, OFS_MODE, 8'h00, 16'hFF48);
        n = 0;
        while (watchdogReset !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check({15'h0, n < 270}, 16'h1);
        apb(1'b1, OFS_CTRL, 8'h04, 16'h0);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : test_cca_capture_compare
`default_nettype wire

/* File: rtl/cca_capture_compare.sv */
`timescale 1ns/1ps
`default_nettype none

module cca_capture_compare
    import cca_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] modulePinIn,
    output logic [2:0] modulePinOut,
    output logic [2:0] modulePinOe,
    input wire logic cpuIdle,
    output logic irqReq,
    output logic watchdogReset
);

    ////////////////////////////////////////////////////////////////////////
    // State

    cca_state_t s;
    cca_state_t next_s;

    logic acc;
    logic wr;
    logic rd;
    logic tbTick;
    logic tick;
    logic [15:0] cntInc;
    logic hit;
    logic [7:0] rv;
    logic [7:0] md;
    logic rise;
    logic fall;
    logic capMode;
    logic cmpMatch;
    logic loMatch;
    logic loWrap;
    logic hiWrap;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign pready = acc;
    assign prdata = s.rdata;
    assign modulePinOut = s.pinOut;
    assign watchdogReset = s.wdReset;

    always_comb begin
        hit = 1'b1;
        if (paddr == OFS_CTRL || paddr == OFS_MODE) begin
            hit = 1'b1;
        end else if (paddr == OFS_CNT_LO || paddr == OFS_CNT_HI) begin
            hit = 1'b1;
        end else if (paddr >= OFS_MODREG && paddr < OFS_CMP_HI + 8'hC) begin
            hit = (paddr[1:0] == 2'h0) && (paddr[3:2] != 2'h3);
        end else begin
            hit = 1'b0;
        end
    end

    assign pslverr = acc & ~hit;

    ////////////////////////////////////////////////////////////////////////
    // Outputs from registers

    always_comb begin
        irqReq = s.ovf & s.ovfIe;
        for (int i = 0; i < NUM_MOD; i++) begin
            irqReq = irqReq | (s.flag[i] & s.mode[i][MM_IE]); // [RULE3]
            // Pin driven only by output modes
            modulePinOe[i] = s.mode[i][MM_ECOM] & (s.mode[i][MM_TOG] | s.mode[i][MM_PWM]);
        end
        if (s.watchdog_enable) begin
            modulePinOe[2] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase and counter

    always_comb begin
        case (s.tb) // [RULE24]
            TB_DIV12: tbTick = (s.div == DIV12_LAST);
            TB_DIV4: tbTick = (s.div[1:0] == DIV4_LAST);
            TB_SYSCLK: tbTick = 1'b1;
            default: tbTick = 1'b0;
        endcase
    end

    // Watchdog keeps the counter running regardless of the run bit
    assign tick = tbTick & (s.run | s.watchdog_enable) & ~(s.idle & cpuIdle); // [RULE19] [RULE20]
    assign cntInc = s.cnt + 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        rv = 8'h00;
        md = 8'h00;
        rise = 1'b0;
        fall = 1'b0;
        capMode = 1'b0;
        cmpMatch = 1'b0;
        loMatch = 1'b0;
        loWrap = 1'b0;
        hiWrap = 1'b0;
        next_s.wdReset = 1'b0;

        if (s.div == DIV12_LAST) begin
            next_s.div = 4'h0;
        end else begin
            next_s.div = s.div + 4'h1;
        end

        // Read data prepared in the setup phase
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                OFS_CTRL: rv = {s.ovf, s.run, 3'b000, s.flag};
                OFS_MODE: rv = {s.idle, s.watchdog_enable, s.lock, 1'b0, s.tb, s.ovfIe};
                OFS_CNT_LO: rv = s.cnt[7:0];
                OFS_CNT_HI: rv = s.snap;
                default: begin
                    for (int i = 0; i < NUM_MOD; i++) begin
                        if (paddr == OFS_MODREG + OFS_STRIDE * 8'(i)) begin
                            rv = s.mode[i];
                        end
                        if (paddr == OFS_CMP_LO + OFS_STRIDE * 8'(i)) begin
                            rv = s.cmpLo[i];
                        end
                        if (paddr == OFS_CMP_HI + OFS_STRIDE * 8'(i)) begin
                            rv = s.cmpHi[i];
                        end
                    end
                end
            endcase
            next_s.rdata = {24'h000000, rv};
        end

        // Reading the low byte freezes the high byte for the next read
        if (rd && paddr == OFS_CNT_LO) begin
            next_s.snap = s.cnt[15:8];
        end

        // Software writes
        if (wr) begin
            case (paddr)
                OFS_CTRL: begin
                    next_s.ovf = pwdata[CTRL_OVF];
                    next_s.run = pwdata[CTRL_RUN];
                    next_s.flag = pwdata[2:0];
                    if (s.watchdog_enable && pwdata[2]) begin
                        next_s.wdReset = 1'b1; // [RULE23]
                    end
                end
                OFS_MODE: begin
                    if (s.watchdog_enable) begin
                        // Only the enable and lock stay writable
                        next_s.watchdog_enable = pwdata[MD_WATCHDOG_ENABLE] | s.lock; // [RULE19]
                        next_s.lock = pwdata[MD_LOCK] | s.lock;
                    end else begin
                        next_s.idle = pwdata[MD_IDLE];
                        next_s.watchdog_enable = pwdata[MD_WATCHDOG_ENABLE] | pwdata[MD_LOCK];
                        next_s.lock = pwdata[MD_LOCK];
                        next_s.tb = pwdata[MD_TB_LSB +: 3];
                        next_s.ovfIe = pwdata[MD_OVF_IE];
                    end
                end
                OFS_CNT_LO: begin
                    if (!s.watchdog_enable) begin
                        next_s.cnt[7:0] = pwdata[7:0]; // [RULE19]
                    end
                end
                OFS_CNT_HI: begin
                    if (!s.watchdog_enable) begin
                        next_s.cnt[15:8] = pwdata[7:0]; // [RULE19]
                    end
                end
                default: begin
                    for (int i = 0; i < NUM_MOD; i++) begin
                        if (paddr == OFS_MODREG + OFS_STRIDE * 8'(i)) begin
                            if (!(i == 2 && s.watchdog_enable)) begin
                                next_s.mode[i] = pwdata[7:0]; // [RULE19]
                            end
                        end
                        if (paddr == OFS_CMP_LO + OFS_STRIDE * 8'(i)) begin
                            next_s.cmpLo[i] = pwdata[7:0];
                            if (!(i == 2 && s.watchdog_enable)) begin
                                next_s.mode[i][MM_ECOM] = 1'b0; // [RULE7]
                            end
                        end
                        if (paddr == OFS_CMP_HI + OFS_STRIDE * 8'(i)) begin
                            if (i == 2 && s.watchdog_enable) begin
                                // Refresh: new deadline from the running count
                                next_s.cmpHi[i] = s.cnt[15:8] + s.cmpLo[i]; // [RULE22]
                            end else begin
                                next_s.cmpHi[i] = pwdata[7:0];
                                next_s.mode[i][MM_ECOM] = 1'b1; // [RULE7] [RULE8]
                            end
                        end
                    end
                end
            endcase
        end

        // Counter advance
        if (tick) begin
            next_s.cnt = cntInc;
            if (cntInc == 16'h0000) begin
                next_s.ovf = 1'b1;
            end
        end

        // Watchdog deadline: low byte wraps while high byte matches
        if (s.watchdog_enable && tick && s.cnt[7:0] == 8'hFF && s.cnt[15:8] == s.cmpHi[2]) begin
            next_s.wdReset = 1'b1; // [RULE17] [RULE21]
        end

        // Per-module behaviour
        for (int i = 0; i < NUM_MOD; i++) begin
            next_s.pinHist[i] = {s.pinHist[i][1:0], modulePinIn[i]};
            // New level must be seen on two samples
            rise = (s.pinHist[i] == 3'b011); // [RULE5]
            fall = (s.pinHist[i] == 3'b100); // [RULE5]
            md = s.mode[i];
            capMode = ~md[MM_MAT] & ~md[MM_TOG] & ~md[MM_PWM];
            cmpMatch = tick && cntInc == {s.cmpHi[i], s.cmpLo[i]};
            loMatch = tick && cntInc[7:0] == s.cmpLo[i];
            loWrap = tick && cntInc[7:0] == 8'h00;
            hiWrap = tick && cntInc == 16'h0000;

            if (i == 2 && s.watchdog_enable) begin
                // Module 2 serves as the watchdog only
                next_s.pinOut[i] = s.pinOut[i]; // [RULE19]
            end else if (capMode) begin
                if ((rise & md[MM_RISE]) | (fall & md[MM_FALL])) begin // [RULE2] [RULE4]
                    {next_s.cmpHi[i], next_s.cmpLo[i]} = s.cnt; // [RULE1]
                    next_s.flag[i] = 1'b1; // [RULE3]
                end
            end else if (md[MM_PWM] && !md[MM_ECOM]) begin
                next_s.pinOut[i] = 1'b0; // [RULE14]
            end else if (md[MM_PWM] && md[MM_TOG]) begin
                if (loMatch) begin
                    next_s.pinOut[i] = ~s.pinOut[i]; // [RULE10]
                    // Adding zero leaves the value: next match is 256 counter ticks away
                    next_s.cmpLo[i] = s.cmpLo[i] + s.cmpHi[i]; // [RULE10] [RULE11]
                    if (md[MM_MAT]) begin
                        next_s.flag[i] = 1'b1;
                    end
                end
            end else if (md[MM_PWM] && md[MM_WIDE]) begin
                if (cmpMatch) begin
                    next_s.pinOut[i] = 1'b1; // [RULE15]
                    if (md[MM_MAT]) begin
                        next_s.flag[i] = 1'b1;
                    end
                end else if (hiWrap) begin
                    next_s.pinOut[i] = 1'b0; // [RULE15]
                end
            end else if (md[MM_PWM]) begin
                if (loWrap) begin
                    next_s.cmpLo[i] = s.cmpHi[i]; // [RULE13]
                    // Zero setting means output never falls
                    next_s.pinOut[i] = (s.cmpHi[i] == 8'h00); // [RULE12]
                end else if (loMatch) begin
                    next_s.pinOut[i] = 1'b1; // [RULE12]
                    if (md[MM_MAT]) begin
                        next_s.flag[i] = 1'b1;
                    end
                end
            end else if (md[MM_ECOM] && md[MM_MAT] && cmpMatch) begin
                next_s.flag[i] = 1'b1; // [RULE6]
                if (md[MM_TOG]) begin
                    next_s.pinOut[i] = ~s.pinOut[i]; // [RULE9]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.watchdog_enable <= RST_MODE[MD_WATCHDOG_ENABLE]; // [RULE18]
            s.tb <= TB_DIV12;
            s.cmpLo <= {RST_BYTE, RST_BYTE, RST_BYTE};
            s.cmpHi <= {RST_BYTE, RST_BYTE, RST_BYTE};
        end else begin
            s <= next_s;
        end
    end

endmodule : cca_capture_compare

`default_nettype wire

/* File: rtl/cca_pkg.sv */
// Overview of operation
// [RULE1] Capture edge copies counter into module register
// [RULE2] Edge selects pick rising, falling or both
// [RULE3] Event sets flag; only software clears it
// [RULE4] Pin level stays readable for both-edge capture
// [RULE5] Pin levels must last two clocks
// [RULE6] Compare match sets flag, requests interrupt
// [RULE7] Low byte write clears, high sets compare
// [RULE8] Software writes low byte before high byte
// [RULE9] High-speed output toggles pin on match
// [RULE10] Frequency output toggles, adds high to low
// [RULE11] Zero half period acts as 256 clocks
// [RULE12] 8-bit PWM: set on match, clear overflow
// [RULE13] Low overflow reloads low byte from high
// [RULE14] Compare disabled PWM holds output low
// [RULE15] 16-bit PWM: set on match, clear overflow
// [RULE16] Software times duty updates to match interrupts
// [RULE17] Watchdog enable turns module 2 into watchdog
// [RULE18] Watchdog enabled after every reset
// [RULE19] Watchdog freezes counter writes, timebase, module 2
// [RULE20] Run bit cannot stop counter under watchdog
// [RULE21] Watchdog high byte match issues reset
// [RULE22] High byte write reloads counter high plus offset
// [RULE23] Writing module 2 flag forces watchdog reset
// [RULE24] Timebase codes select divide twelve, four, one
package cca_pkg;

    localparam int NUM_MOD = 3;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_MODREG = 8'h10;
    localparam logic [7:0] OFS_CMP_LO = 8'h20;
    localparam logic [7:0] OFS_CMP_HI = 8'h30;
    localparam logic [7:0] OFS_STRIDE = 8'h04;

    // array_control_reg fields
    localparam int CTRL_OVF = 7;
    localparam int CTRL_RUN = 6;

    // array_mode_reg fields
    localparam int MD_IDLE = 7;
    localparam int MD_WATCHDOG_ENABLE = 6;
    localparam int MD_LOCK = 5;
    localparam int MD_TB_LSB = 1;
    localparam int MD_OVF_IE = 0;

    // module_mode_reg fields
    localparam int MM_WIDE = 7;
    localparam int MM_ECOM = 6;
    localparam int MM_RISE = 5;
    localparam int MM_FALL = 4;
    localparam int MM_MAT = 3;
    localparam int MM_TOG = 2;
    localparam int MM_PWM = 1;
    localparam int MM_IE = 0;

    // Reset values
    localparam logic [7:0] RST_MODE = 8'h40;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Timebase codes
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_SYSCLK = 3'h4;

    // Timebase divider
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0] snap;
        logic ovf;
        logic run;
        logic [2:0] flag;
        logic idle;
        logic watchdog_enable;
        logic lock;
        logic [2:0] tb;
        logic ovfIe;
        logic [2:0][7:0] mode;
        logic [2:0][7:0] cmpLo;
        logic [2:0][7:0] cmpHi;
        logic [2:0] pinOut;
        logic [2:0][2:0] pinHist;
        logic [3:0] div;
        logic [31:0] rdata;
        logic wdReset;
    } cca_state_t;

endpackage : cca_pkg
